// file: common/prs_regs.vh
// Register offsets, field layouts, reset values and encodings of the regulator state bank.
`ifndef PRS_REGS_VH
`define PRS_REGS_VH

// Register offsets on the serial control bus.
`define PRS_ADDR_BCAST_PROV     8'h33
`define PRS_ADDR_BCAST_CLK_RST  8'h34
`define PRS_ADDR_REG4_MODE      8'h41
`define PRS_ADDR_REG4_STATE     8'h42
`define PRS_ADDR_REG4_VOLTAGE   8'h44
`define PRS_ADDR_REG5_MODE      8'h47

// Resource state encoding.
`define PRS_STATE_OFF           2'h0
`define PRS_STATE_ON            2'h1
`define PRS_STATE_OFF_ALT       2'h2
`define PRS_STATE_SLEEP         2'h3
`define PRS_STATE_RESET         2'h0

// Mode command encoding.
`define PRS_MODE_OFF            2'h0
`define PRS_MODE_AUTO           2'h1
`define PRS_MODE_RESERVED       2'h2
`define PRS_MODE_FORCE_PWM      2'h3

// Mode command register layout: off in 5:4, sleep in 3:2, active in 1:0.
`define PRS_MODE_OFF_HI         5
`define PRS_MODE_OFF_LO         4
`define PRS_MODE_SLEEP_HI       3
`define PRS_MODE_SLEEP_LO       2
`define PRS_MODE_ACT_HI         1
`define PRS_MODE_ACT_LO         0
`define PRS_MODE_RESET          6'h05
`define PRS_MODE_WR_MASK        6'h06

// Voltage select register layout.
`define PRS_VOLT_KEEP_BIT       7
`define PRS_VOLT_CODE_HI        5
`define PRS_VOLT_CODE_LO        0
`define PRS_VOLT_CODE_ZERO      6'h00
`define PRS_VOLT_CODE_RSVD      6'h3F
`define PRS_VOLT_KEEP_RESET     1'b0

`endif

// file: rtl/prs_resource_state.v
// One resource state holder, driven by broadcast and by its own command register.
`timescale 1ns/100ps
`default_nettype none

`include "prs_regs.vh"

module prs_resource_state (
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire       bcast_wr,
  input  wire [1:0] bcast_state,
  input  wire       targeted,
  input  wire       own_wr,
  input  wire [1:0] own_state,
  input  wire       force_off,
  input  wire       restore,
  output reg  [1:0] state,
  output reg        res_on,
  output reg        res_sleep
);

  reg  [1:0] cmd;
  reg        held;
  reg  [1:0] next_cmd;
  reg        next_held;
  reg  [1:0] next_state;

  // Decode of the two-bit state field into on.
  function is_on;
    input [1:0] s;
    begin
      is_on = (s == `PRS_STATE_ON);
    end
  endfunction

  // Decode of the two-bit state field into sleep.
  function is_sleep;
    input [1:0] s;
    begin
      is_sleep = (s == `PRS_STATE_SLEEP);
    end
  endfunction

  // Next command, hold flag and visible state.
  always @* begin
    next_cmd  = cmd;
    next_held = held;
    if (bcast_wr && targeted) begin
      next_cmd = bcast_state;
    end
    if (own_wr) begin
      next_cmd = own_state;
    end
    if (restore) begin
      next_held = 1'b0;
    end
    if (force_off) begin
      next_held = 1'b1;
    end
    next_state = next_held ? `PRS_STATE_OFF : next_cmd;
  end

  // State registers.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd       <= `PRS_STATE_RESET;
      held      <= 1'b0;
      state     <= `PRS_STATE_RESET;
      res_on    <= 1'b0;
      res_sleep <= 1'b0;
    end else begin
      cmd       <= next_cmd;
      held      <= next_held;
      state     <= next_state;
      res_on    <= is_on(next_state);
      res_sleep <= is_sleep(next_state);
    end
  end

endmodule // prs_resource_state

`default_nettype wire

// file: rtl/prs_regs.v
// Regulator state register bank: broadcast state, mode commands and voltage select.
`timescale 1ns/100ps
`default_nettype none

`include "prs_regs.vh"

module prs_regs #(
  parameter NUM_PROV   = 18,
  parameter NUM_CLKRST = 8
) (
  input  wire                    ref_clk,
  input  wire                    arst_n,
  input  wire                    reg_wr_en,
  input  wire                    reg_rd_en,
  input  wire [7:0]              reg_addr,
  input  wire [7:0]              reg_wdata,
  output reg  [7:0]              reg_rdata,
  input  wire [NUM_PROV-1:0]     prov_group_membership,
  input  wire [NUM_CLKRST-1:0]   clkrst_group_membership,
  input  wire [5:0]              default_voltage_code,
  input  wire                    extended_range_cfg,
  input  wire                    wait_on_entry,
  input  wire                    warm_reset,
  output wire [2*NUM_PROV-1:0]   prov_state,
  output wire [NUM_PROV-1:0]     prov_on,
  output wire [NUM_PROV-1:0]     prov_sleep,
  output wire [2*NUM_CLKRST-1:0] clkrst_state,
  output wire [NUM_CLKRST-1:0]   clkrst_on,
  output wire [NUM_CLKRST-1:0]   clkrst_sleep,
  output reg  [5:0]              reg4_voltage_code,
  output reg                     reg4_voltage_keep,
  output reg  [5:0]              reg4_mode_cmd,
  output reg  [5:0]              reg5_mode_cmd,
  output reg                     extended_mode,
  output reg                     voltage_code_reserved
);

  reg        init_pending;
  reg  [5:0] next_code;
  reg        next_keep;
  reg  [7:0] next_rdata;
  wire       wr_bcast_prov;
  wire       wr_bcast_clkrst;
  wire       wr_reg4_state;
  wire       wr_reg4_volt;
  wire       wr_reg4_mode;
  wire       wr_reg5_mode;
  wire       zero_write;
  wire       restore_write;
  wire       load_default;

  // Write strobes per register.
  assign wr_bcast_prov   = reg_wr_en && (reg_addr == `PRS_ADDR_BCAST_PROV);
  assign wr_bcast_clkrst = reg_wr_en && (reg_addr == `PRS_ADDR_BCAST_CLK_RST);
  assign wr_reg4_state   = reg_wr_en && (reg_addr == `PRS_ADDR_REG4_STATE);
  assign wr_reg4_volt    = reg_wr_en && (reg_addr == `PRS_ADDR_REG4_VOLTAGE);
  assign wr_reg4_mode    = reg_wr_en && (reg_addr == `PRS_ADDR_REG4_MODE);
  assign wr_reg5_mode    = reg_wr_en && (reg_addr == `PRS_ADDR_REG5_MODE);

  // Zero and restore events come only from bus writes of the voltage code.
  assign zero_write    = wr_reg4_volt &&
                         (reg_wdata[`PRS_VOLT_CODE_HI:`PRS_VOLT_CODE_LO] == `PRS_VOLT_CODE_ZERO);
  assign restore_write = wr_reg4_volt && !zero_write &&
                         (reg4_voltage_code == `PRS_VOLT_CODE_ZERO);

  assign load_default = init_pending || wait_on_entry || (warm_reset && !reg4_voltage_keep);

  // Provider resources; index 0 is regulator 4 with its own state register.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PROV; gi = gi + 1) begin : g_prov
      prs_resource_state u_res (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .bcast_wr    (wr_bcast_prov),
        .bcast_state (reg_wdata[1:0]),
        .targeted    (prov_group_membership[gi]),
        .own_wr      ((gi == 0) ? wr_reg4_state : 1'b0),
        .own_state   (reg_wdata[1:0]),
        .force_off   ((gi == 0) ? zero_write : 1'b0),
        .restore     ((gi == 0) ? restore_write : 1'b0),
        .state       (prov_state[2*gi+1:2*gi]),
        .res_on      (prov_on[gi]),
        .res_sleep   (prov_sleep[gi])
      );
    end
    // Clock, reset and comparator resources; the top index is the system enable output.
    for (gi = 0; gi < NUM_CLKRST; gi = gi + 1) begin : g_clkrst
      prs_resource_state u_res (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .bcast_wr    (wr_bcast_clkrst),
        .bcast_state (reg_wdata[1:0]),
        .targeted    (clkrst_group_membership[gi]),
        .own_wr      (1'b0),
        .own_state   (`PRS_STATE_RESET),
        .force_off   (1'b0),
        .restore     (1'b0),
        .state       (clkrst_state[2*gi+1:2*gi]),
        .res_on      (clkrst_on[gi]),
        .res_sleep   (clkrst_sleep[gi])
      );
    end
  endgenerate

  // Next voltage code and keep bit; a default load wins over a bus write of the code in the same cycle, not of the keep bit.
  always @* begin
    next_code = reg4_voltage_code;
    next_keep = reg4_voltage_keep;
    if (wr_reg4_volt) begin
      next_code = reg_wdata[`PRS_VOLT_CODE_HI:`PRS_VOLT_CODE_LO];
      next_keep = reg_wdata[`PRS_VOLT_KEEP_BIT];
    end
    if (load_default) begin
      next_code = default_voltage_code;
    end
  end

  // Voltage select register and the one-shot default load after reset release.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_pending          <= 1'b1;
      reg4_voltage_code     <= `PRS_VOLT_CODE_ZERO;
      reg4_voltage_keep     <= `PRS_VOLT_KEEP_RESET;
      voltage_code_reserved <= 1'b0;
    end else begin
      init_pending          <= 1'b0;
      reg4_voltage_code     <= next_code;
      reg4_voltage_keep     <= next_keep;
      voltage_code_reserved <= (next_code == `PRS_VOLT_CODE_RSVD);
    end
  end

  // Mode command registers; only the writable bits take bus data.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg4_mode_cmd <= `PRS_MODE_RESET;
      reg5_mode_cmd <= `PRS_MODE_RESET;
    end else begin
      if (wr_reg4_mode) begin
        reg4_mode_cmd <= (reg4_mode_cmd & ~`PRS_MODE_WR_MASK) |
                         (reg_wdata[5:0] & `PRS_MODE_WR_MASK);
      end
      if (wr_reg5_mode) begin
        reg5_mode_cmd <= (reg5_mode_cmd & ~`PRS_MODE_WR_MASK) |
                         (reg_wdata[5:0] & `PRS_MODE_WR_MASK);
      end
    end
  end

  // Extended interpretation follows the nonvolatile strap only.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      extended_mode <= 1'b0;
    end else begin
      extended_mode <= extended_range_cfg;
    end
  end

  // Read multiplexer; broadcast registers are write-only and read zero.
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PRS_ADDR_REG4_MODE: begin
        next_rdata = {2'b00, reg4_mode_cmd};
      end
      `PRS_ADDR_REG4_STATE: begin
        next_rdata = {6'b00_0000, prov_state[1:0]};
      end
      `PRS_ADDR_REG4_VOLTAGE: begin
        next_rdata = {reg4_voltage_keep, 1'b0, reg4_voltage_code};
      end
      `PRS_ADDR_REG5_MODE: begin
        next_rdata = {2'b00, reg5_mode_cmd};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data register, updated only on a read strobe.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // prs_regs

`default_nettype wire

// file: sim/prs_host.sv
// Host model that drives the register strobe port of the regulator bank.
`timescale 1ns/100ps
`default_nettype none
module prs_host (
  input  wire logic       ref_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero.
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write strobe; released data lines carry the inverse value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  // One read strobe; the data is taken once the answering edge has passed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule // prs_host
`default_nettype wire

// file: sim/prs_regs_monitor.sv
// Port checker of the regulator state bank.
`timescale 1ns/100ps
`default_nettype none
module prs_regs_monitor #(
  parameter NUM_PROV   = 18,
  parameter NUM_CLKRST = 8
) (
  input wire logic                    ref_clk,
  input wire logic                    arst_n,
  input wire logic                    reg_wr_en,
  input wire logic [7:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic [NUM_PROV-1:0]     prov_group_membership,
  input wire logic [NUM_CLKRST-1:0]   clkrst_group_membership,
  input wire logic [5:0]              default_voltage_code,
  input wire logic                    extended_range_cfg,
  input wire logic                    wait_on_entry,
  input wire logic                    warm_reset,
  input wire logic [2*NUM_PROV-1:0]   prov_state,
  input wire logic [NUM_PROV-1:0]     prov_on,
  input wire logic [NUM_PROV-1:0]     prov_sleep,
  input wire logic [2*NUM_CLKRST-1:0] clkrst_state,
  input wire logic [5:0]              reg4_voltage_code,
  input wire logic                    reg4_voltage_keep,
  input wire logic [5:0]              reg4_mode_cmd,
  input wire logic                    extended_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Write strobes decoded per register.
  wire w33 = reg_wr_en && reg_addr == 8'h33;
  wire w34 = reg_wr_en && reg_addr == 8'h34;
  wire w44 = reg_wr_en && reg_addr == 8'h44;
  a_on_sleep_decode: assert property (prov_on[0] == (prov_state[1:0] == 2'h1) &&
    prov_sleep[0] == (prov_state[1:0] == 2'h3)) else $error("decoded flags wrong");
  a_own_state_wr: assert property (reg_wr_en && reg_addr == 8'h42 && reg4_voltage_code != 0
    |=> prov_state[1:0] == $past(reg_wdata[1:0])) else $error("own state write lost");
  a_bcast_prov_hit: assert property (w33 && prov_group_membership[1]
    |=> prov_state[3:2] == $past(reg_wdata[1:0])) else $error("provider broadcast lost");
  a_bcast_prov_skip: assert property (w33 && !prov_group_membership[2]
    |=> $stable(prov_state[5:4])) else $error("untargeted provider changed");
  a_bcast_clkrst_hit: assert property (w34 && clkrst_group_membership[NUM_CLKRST-1]
    |=> clkrst_state[2*NUM_CLKRST-1 -: 2] == $past(reg_wdata[1:0]))
    else $error("clock reset broadcast lost");
  a_zero_code_off: assert property (w44 && reg_wdata[5:0] == 0 && !wait_on_entry &&
    !warm_reset |=> prov_state[1:0] == 2'h0 && reg4_voltage_code == 0) else $error("not off");
  a_wait_on_reload: assert property (wait_on_entry
    |=> reg4_voltage_code == $past(default_voltage_code)) else $error("no default reload");
  a_warm_reload: assert property (warm_reset && !reg4_voltage_keep
    |=> reg4_voltage_code == $past(default_voltage_code)) else $error("warm reload missing");
  a_warm_keep: assert property (warm_reset && reg4_voltage_keep && !reg_wr_en &&
    !wait_on_entry |=> $stable(reg4_voltage_code)) else $error("warm keep failed");
  a_mode_fixed_bits: assert property ((reg4_mode_cmd & 6'h39) == 6'h01)
    else $error("mode fixed bits wrong");
  a_ext_follows_cfg: assert property (1'b1 |=> extended_mode == $past(extended_range_cfg))
    else $error("extended mode not following");
  c_zero_code: cover property (w44 && reg_wdata[5:0] == 0);
  c_warm_keep: cover property (warm_reset && reg4_voltage_keep);
  c_bcast_skip: cover property (w33 && !prov_group_membership[2]);
endmodule // prs_regs_monitor
bind prs_regs prs_regs_monitor #(.NUM_PROV(NUM_PROV), .NUM_CLKRST(NUM_CLKRST)) mon_i (.*);
`default_nettype wire

// file: sim/prs_regs_test.sv
// Self-checking bench of the regulator state bank.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module prs_regs_test;
  logic        ref_clk = 0, arst_n = 0, wr, rdn, woe = 0, wrs = 0, ext = 0;
  logic [7:0]  addr, wdat, rdat, v;
  logic [17:0] pgm = 18'h3_FFFF;
  logic [7:0]  cgm = 8'hFF;
  logic [35:0] pst;
  logic [17:0] pon, psl;
  logic [15:0] cst;
  logic [7:0]  con, csl;
  logic [5:0]  code, m4, m5;
  logic [5:0]  dvc = 6'h2D;
  logic        keep, extm, rsv;
  int          n_fail = 0, tests_run = 0;
  // Write then read rows {waddr, wdata, raddr, expected}; no mode field gets 10.
  logic [31:0] rows [11] = '{32'h4201_4201, 32'h4203_4203, 32'h4202_4202, 32'h42FC_4200,
    32'h41FF_4107, 32'h4700_4701, 32'h44FF_44BF, 32'h442A_442A, 32'h3301_4201,
    32'h3403_3400, 32'h5077_5000};
  prs_host prs_host_i (.ref_clk(ref_clk), .reg_wr_en(wr), .reg_rd_en(rdn), .reg_addr(addr),
    .reg_wdata(wdat), .reg_rdata(rdat));
  prs_regs #(.NUM_PROV(18), .NUM_CLKRST(8)) prs_regs_i (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_wr_en(wr), .reg_rd_en(rdn), .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat),
    .prov_group_membership(pgm), .clkrst_group_membership(cgm),
    .default_voltage_code(dvc), .extended_range_cfg(ext), .wait_on_entry(woe),
    .warm_reset(wrs), .prov_state(pst), .prov_on(pon), .prov_sleep(psl),
    .clkrst_state(cst), .clkrst_on(con), .clkrst_sleep(csl), .reg4_voltage_code(code),
    .reg4_voltage_keep(keep), .reg4_mode_cmd(m4), .reg5_mode_cmd(m5),
    .extended_mode(extm), .voltage_code_reserved(rsv));
  // Clock at 250 MHz.
  always #2 ref_clk = ~ref_clk;
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog at 10000 cycles, well beyond the roughly 115 cycles the sequence needs.
  initial begin
    #40000;
    n_fail++;
    stop_test();
  end
  // Main sequence.
  initial begin
    repeat (20) @(negedge ref_clk);
    arst_n = 1;
    prs_host_i.rd(8'h41, v); `CHK(v, 8'h05)
    prs_host_i.rd(8'h47, v); `CHK(v, 8'h05)
    prs_host_i.rd(8'h42, v); `CHK(v, 8'h00)
    prs_host_i.rd(8'h44, v); `CHK(v, 8'h2D)
    foreach (rows[i]) begin
      prs_host_i.wr(rows[i][31:24], rows[i][23:16]);
      prs_host_i.rd(rows[i][15:8], v); `CHK(v, rows[i][7:0])
    end
    `CHK(rsv, 1'b0)
    // Provider 2 and the system enable keep the states that the row broadcasts gave them.
    pgm = 18'h3_FFFB;
    cgm = 8'h7F;
    for (int s = 0; s < 4; s++) begin
      prs_host_i.wr(8'h33, 8'hFC | s[7:0]);
      prs_host_i.wr(8'h34, s[7:0]);
      `CHK(({pst[3:2], pon[1], psl[1]}), ({s[1:0], s == 1, s == 3}))
      `CHK(pst[5:4], 2'h1)
      `CHK(({con[0], csl[0], cst[15:14]}), ({s == 1, s == 3, 2'h3}))
    end
    prs_host_i.wr(8'h42, 8'h03);
    prs_host_i.wr(8'h44, 8'h00); `CHK(pst[1:0], 2'h0)
    prs_host_i.wr(8'h42, 8'h01); `CHK(pst[1:0], 2'h0)
    prs_host_i.wr(8'h44, 8'h95); `CHK(pst[1:0], 2'h1)
    `CHK(keep, 1'b1)
    @(negedge ref_clk) wrs = 1;
    @(negedge ref_clk) wrs = 0;
    `CHK(code, 6'h15)
    prs_host_i.wr(8'h44, 8'h15);
    @(negedge ref_clk) wrs = 1;
    @(negedge ref_clk) wrs = 0;
    `CHK(code, 6'h2D)
    prs_host_i.wr(8'h44, 8'h3F); `CHK(code, 6'h3F)
    `CHK(rsv, 1'b1)
    // A new default shows that the reload takes the strap value, not a stored copy.
    dvc = 6'h11;
    @(negedge ref_clk) woe = 1;
    @(negedge ref_clk) woe = 0;
    `CHK(code, 6'h11)
    prs_host_i.wr(8'h41, 8'h00); `CHK(m4, 6'h01)
    prs_host_i.wr(8'h47, 8'h06); `CHK(m5, 6'h07)
    ext = 1;
    repeat (2) @(negedge ref_clk);
    `CHK(extm, 1'b1)
    arst_n = 0;
    @(negedge ref_clk);
    `CHK(({pst[1:0], m4, m5}), ({2'h0, 6'h05, 6'h05}))
    `CHK(({rdat, code, keep, extm, rsv}), ({8'h00, 6'h00, 1'b0, 1'b0, 1'b0}))
    stop_test();
  end
endmodule // prs_regs_test
`default_nettype wire
